// ==== dv/ill_chk.sv ====
`timescale 1ns/1ns
module ill_chk
  import ill_pkg::*;
#(
  parameter int ADDR_W = 3  // Select pin count, as on the top
) (
  input wire logic              clk,
  input wire logic              rst,
  input wire logic              scl_i,
  input wire logic              sda_i,
  input wire logic [ADDR_W-1:0] addr_sel,
  input wire logic              sda_o,
  input wire logic              sda_oe_n,
  input wire logic [7:0]        output_transistor
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Reset must act while it is high, so no disable here
  rst_clear_a: assert property (disable iff (1'b0) rst |=>
    output_transistor == 8'h00 && sda_oe_n) else $error("reset not clean");
  post_reset_a: assert property ($fell(rst) |->
    (sda_oe_n && output_transistor == 8'h00) [*3]) else $error("early drive");
  // Drive only moves well inside the SCL low phase
  ack_edge_a: assert property ($fell(sda_oe_n) |->
    !scl_i && !$past(scl_i, 2)) else $error("drive began in SCL high");
  release_a: assert property ($rose(sda_oe_n) |->
    !scl_i && !$past(scl_i, 2)) else $error("release in SCL high");
  ack_hold_a: assert property ($fell(sda_oe_n) |=>
    !sda_oe_n [*7]) else $error("drive shorter than a bit");
  drive_low_a: assert property (!sda_oe_n |-> sda_o == 1'b0)
    else $error("SDA driven high");
  // Outputs move only while the device pulls SDA low for an acknowledge
  out_move_a: assert property ($changed(output_transistor) &&
    !$past(rst) |-> !sda_oe_n && !scl_i) else $error("stray output move");
  // A start always begins a fresh address byte, never an acknowledge
  start_quiet_a: assert property (scl_i && $fell(sda_i) |->
    sda_oe_n [*8]) else $error("drive right after start");
  cover property ($fell(sda_oe_n));
  cover property ($changed(output_transistor) && !$past(rst));
  cover property (scl_i && $rose(sda_i));
endmodule // ill_chk

bind ill_top ill_chk #(.ADDR_W(ADDR_W)) u_chk (.clk(clk), .rst(rst),
  .scl_i(scl_i), .sda_i(sda_i), .addr_sel(addr_sel), .sda_o(sda_o),
  .sda_oe_n(sda_oe_n), .output_transistor(output_transistor));

// ==== dv/ill_ctl.sv ====
`timescale 1ns/1ns
module ill_ctl (
  input  wire logic clk,       // Bench clock
  input  wire logic sda_in,    // Resolved SDA level
  output logic      scl,       // Bus clock, still between a stop and the next start
  output logic      sda_drv_n  // Low pulls SDA down
);
  initial begin
    scl = 1'b1;
    sda_drv_n = 1'b1;
  end
  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask
  // SDA moves a clock after SCL falls, so hold time is kept
  task automatic bit_x(input logic b, output logic r);
    w(1);
    sda_drv_n <= b;
    w(3);
    scl <= 1'b1;
    w(2);
    r = sda_in;
    w(2);
    scl <= 1'b0;
  endtask
  // One byte, most significant bit first, then the ack slot
  task automatic byte_x(input logic [7:0] wd, output logic [7:0] rd,
                        output logic [7:0] ak);
    logic b;
    for (int j = 7; j >= 0; j--) begin
      bit_x(wd[j], b);
      rd[j] = b;
    end
    bit_x(1'b1, b);
    ak = {7'h00, ~b};
  endtask
  task automatic start;
    w(1);
    sda_drv_n <= 1'b1;
    w(3);
    scl <= 1'b1;
    w(4);
    sda_drv_n <= 1'b0;  // Falls while SCL is high
    w(4);
    scl <= 1'b0;
  endtask
  task automatic stop;
    w(1);
    sda_drv_n <= 1'b0;
    w(3);
    scl <= 1'b1;
    w(4);
    sda_drv_n <= 1'b1;  // Rises while SCL is high
    w(4);
  endtask
endmodule // ill_ctl

// ==== dv/ill_top_tb.sv ====
`timescale 1ns/1ns
module ill_top_tb;
  import ill_pkg::*;
  logic       clk, rst, scl, ctl_n, sda_o, sda_oe_n, sda;
  logic [2:0] addr_sel;
  logic [7:0] output_transistor, sh_m, out_m, cmd;  // Shadow registers
  logic [7:0] cmds [3] = '{ILL_CMD_SHIFT, ILL_CMD_XFER, ILL_CMD_LOAD};
  logic [31:0] rv;
  int         failures, num_checks, seed;
  assign sda = ctl_n & (sda_oe_n | sda_o);  // Wired AND with pull-up
  ill_ctl ctl (.clk(clk), .sda_in(sda), .scl(scl), .sda_drv_n(ctl_n));
  ill_top dut (.clk(clk), .rst(rst), .scl_i(scl), .sda_i(sda),
    .addr_sel(addr_sel), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
    .output_transistor(output_transistor));
  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  function automatic logic known(input logic [7:0] c);
    return c == ILL_CMD_SHIFT || c == ILL_CMD_XFER || c == ILL_CMD_LOAD;
  endfunction
  // One transaction; p low leaves the bus for a repeated start
  task automatic xfer(input logic [3:0] g, input logic [2:0] a, input logic w,
                      input logic [7:0] c, input logic [7:0] d, input logic p);
    logic       hit, wr_ok;
    logic [7:0] r, ak;
    hit = g == ILL_GROUP_CODE && a == addr_sel;
    // Data is taken only on a write to a known loading command
    wr_ok = !w && hit && known(c) && c != ILL_CMD_XFER;
    ctl.start();
    ctl.byte_x({g, a, w}, r, ak);
    chk("addr ack", ak, {7'h00, hit});
    ctl.byte_x(c, r, ak);
    chk("cmd ack", ak, {7'h00, hit && known(c)});
    if (hit && c == ILL_CMD_XFER && !w) out_m = sh_m;
    if (!w || !(hit && c == ILL_CMD_SHIFT)) begin
      // A data byte follows; on a read address it must be ignored
      ctl.byte_x(d, r, ak);
      chk("data ack", ak, {7'h00, wr_ok});
      if (wr_ok) sh_m = d;
      if (wr_ok && c == ILL_CMD_LOAD) out_m = d;
    end else begin
      ctl.byte_x(8'hFF, r, ak);
      chk("read data", r, sh_m);
    end
    if (p) ctl.stop();
    ctl.w(4);
    chk("outputs", output_transistor, out_m);
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Guard against a hang
  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    give_verdict();
  end
  initial begin
    rst = 1'b1;
    addr_sel = 3'h5;
    seed = 59;
    sh_m = ILL_SHIFT_RST;
    out_m = ILL_OUT_RST;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    chk("reset outputs", output_transistor, ILL_OUT_RST);
    xfer(ILL_GROUP_CODE, 3'h5, 1'b0, ILL_CMD_LOAD, 8'hA5, 1'b1);
    xfer(ILL_GROUP_CODE, 3'h5, 1'b0, ILL_CMD_SHIFT, 8'h3C, 1'b0);
    xfer(ILL_GROUP_CODE, 3'h5, 1'b1, ILL_CMD_SHIFT, 8'h00, 1'b1);
    // Transfer with a read address must leave the outputs alone
    xfer(ILL_GROUP_CODE, 3'h5, 1'b1, ILL_CMD_XFER, 8'hC3, 1'b1);
    xfer(ILL_GROUP_CODE, 3'h5, 1'b0, ILL_CMD_XFER, 8'hFF, 1'b1);
    xfer(ILL_GROUP_CODE, 3'h5, 1'b0, 8'h33, 8'h00, 1'b1);
    xfer(4'hD, 3'h5, 1'b0, ILL_CMD_LOAD, 8'h0F, 1'b1);
    xfer(ILL_GROUP_CODE, 3'h4, 1'b0, ILL_CMD_LOAD, 8'h0F, 1'b1);
    xfer(ILL_GROUP_CODE, 3'h5, 1'b1, ILL_CMD_LOAD, 8'h5A, 1'b1);
    // Reset in mid-run with outputs lit must clear both registers
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    sh_m = ILL_SHIFT_RST;
    out_m = ILL_OUT_RST;
    repeat (4) @(posedge clk);
    chk("reset outputs", output_transistor, out_m);
    // Read back proves the shift register was cleared too
    xfer(ILL_GROUP_CODE, 3'h5, 1'b1, ILL_CMD_SHIFT, 8'h00, 1'b1);
    // Random traffic: mixed commands, addresses and repeated starts
    for (int i = 0; i < 14; i++) begin
      rv = $random(seed);
      addr_sel <= rv[2:0];
      @(posedge clk);
      cmd = rv[5:4] == 2'h3 ? rv[15:8] : cmds[rv[5:4]];
      xfer(rv[7:6] == 2'h0 ? 4'h3 : ILL_GROUP_CODE,
           rv[16] ? rv[2:0] : rv[19:17], rv[3], cmd, rv[31:24], rv[20]);
    end
    give_verdict();
  end
endmodule // ill_top_tb

// ==== logic/ill_pkg.sv ====
package ill_pkg;

  // Fixed group code in the upper address nibble
  localparam logic [3:0] ILL_GROUP_CODE = 4'hC;
  // Subaddress commands
  localparam logic [7:0] ILL_CMD_SHIFT  = 8'h11;
  localparam logic [7:0] ILL_CMD_XFER   = 8'h22;
  localparam logic [7:0] ILL_CMD_LOAD   = 8'h44;
  // Reset values of the two data registers
  localparam logic [7:0] ILL_SHIFT_RST  = 8'h00;
  localparam logic [7:0] ILL_OUT_RST    = 8'h00;
  // Bits in one serial byte
  localparam logic [3:0] ILL_BYTE_BITS  = 4'h8;
  // Field positions inside the address byte
  localparam int ILL_GRP_MSB = 7;
  localparam int ILL_GRP_LSB = 4;
  localparam int ILL_ADR_MSB = 3;
  localparam int ILL_ADR_LSB = 1;
  localparam int ILL_RW_BIT  = 0;

  // One sample of the two bus wires, travelling together
  typedef struct packed {
    logic scl;
    logic sda;
  } ill_bus_t;

  // Serial engine states, one-hot
  typedef enum logic [9:0] {
    ST_IDLE     = 10'h001,
    ST_ADDR     = 10'h002,
    ST_ADDR_ACK = 10'h004,
    ST_CMD      = 10'h008,
    ST_CMD_ACK  = 10'h010,
    ST_WDATA    = 10'h020,
    ST_WDAT_ACK = 10'h040,
    ST_RDATA    = 10'h080,
    ST_RDAT_ACK = 10'h100,
    ST_IGNORE   = 10'h200
  } ill_state_t;

endpackage

// ==== logic/ill_top.sv ====
`timescale 1ns/1ns
module ill_top
  import ill_pkg::*;
#(
  parameter int ADDR_W = 3  // Width of the address-select pin group
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              scl_i,
  input  wire logic              sda_i,
  input  wire logic [ADDR_W-1:0] addr_sel,
  output logic                   sda_o,
  output logic                   sda_oe_n,
  output logic [7:0]             output_transistor
);

  // Synchroniser stages for the bus wires and the select pins
  ill_bus_t          bus_s1_q;   // First stage, read only by second
  ill_bus_t          bus_q;      // Settled bus sample
  ill_bus_t          bus_p_q;    // Previous settled sample
  logic [ADDR_W-1:0] sel_s1_q;   // First stage of the select pins
  logic [ADDR_W-1:0] sel_q;      // Settled select pins

  // Serial engine state
  ill_state_t state_q, state_d;  // Current transaction phase
  logic [3:0] cnt_q,   cnt_d;    // Bits seen in the current byte
  logic [7:0] rx_q,    rx_d;     // Incoming byte assembly
  logic       rw_q,    rw_d;     // Direction bit of the address byte
  logic [7:0] cmd_q,   cmd_d;    // Latched subaddress
  logic [7:0] tx_q,    tx_d;     // Outgoing byte during a read
  logic [7:0] shreg_q, shreg_d;  // Data shift register
  logic [7:0] out_q,   out_d;    // Output storage register
  logic       oe_n_q,  oe_n_d;   // Low while pulling SDA low
  logic       sdo_q;             // Data level driven on SDA

  // Decoded bus events
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;

  // True when the address byte selects this device
  function automatic logic addr_hit(input logic [7:0]        b,
                                    input logic [ADDR_W-1:0] s);
    addr_hit = (b[ILL_GRP_MSB:ILL_GRP_LSB] == ILL_GROUP_CODE) &&
               (b[ILL_ADR_MSB:ILL_ADR_LSB] == s);
  endfunction

  // True for the three subaddresses the device knows
  function automatic logic cmd_known(input logic [7:0] c);
    cmd_known = (c == ILL_CMD_SHIFT) || (c == ILL_CMD_XFER) ||
                (c == ILL_CMD_LOAD);
  endfunction

  // Two flops on every bus and select pin before any logic reads it
  always_ff @(posedge clk) begin
    if (rst) begin
      bus_s1_q <= '1;
      bus_q    <= '1;
      bus_p_q  <= '1;
      sel_s1_q <= '0;
      sel_q    <= '0;
    end else begin
      bus_s1_q <= '{scl: scl_i, sda: sda_i};
      bus_q    <= bus_s1_q;
      bus_p_q  <= bus_q;
      sel_s1_q <= addr_sel;
      sel_q    <= sel_s1_q;
    end
  end

  // Edges of SCL and the SDA edges that mark frame limits
  always_comb begin
    scl_rise   = bus_q.scl & ~bus_p_q.scl;
    scl_fall   = ~bus_q.scl & bus_p_q.scl;
    // SDA moving while SCL stays high is a start or a stop
    start_cond = bus_q.scl & bus_p_q.scl & bus_p_q.sda & ~bus_q.sda;
    stop_cond  = bus_q.scl & bus_p_q.scl & ~bus_p_q.sda & bus_q.sda;
  end

  // Next-state logic of the serial engine and data registers
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    rx_d    = rx_q;
    rw_d    = rw_q;
    cmd_d   = cmd_q;
    tx_d    = tx_q;
    shreg_d = shreg_q;  // Held unless a write loads it
    out_d   = out_q;
    oe_n_d  = oe_n_q;
    if (stop_cond) begin
      // Stop ends everything and frees the line
      state_d = ST_IDLE;
      oe_n_d  = 1'b1;
    end else if (start_cond) begin
      // Start or repeated start restarts address capture
      state_d = ST_ADDR;
      cnt_d   = 4'h0;
      oe_n_d  = 1'b1;
    end else begin
      case (state_q)
        ST_ADDR: begin
          if (scl_rise) begin
            // Bits arrive MSB first
            rx_d  = {rx_q[6:0], bus_q.sda};
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == ILL_BYTE_BITS) begin
            cnt_d = 4'h0;
            if (addr_hit(rx_q, sel_q)) begin
              // Match: pull SDA low for the acknowledge
              rw_d    = rx_q[ILL_RW_BIT];
              oe_n_d  = 1'b0;
              state_d = ST_ADDR_ACK;
            end else begin
              // Not ours: stay off the line until a start
              state_d = ST_IGNORE;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            oe_n_d  = 1'b1;
            state_d = ST_CMD;
          end
        end
        ST_CMD: begin
          if (scl_rise) begin
            rx_d  = {rx_q[6:0], bus_q.sda};
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == ILL_BYTE_BITS) begin
            cnt_d = 4'h0;
            cmd_d = rx_q;
            if (cmd_known(rx_q)) begin
              // Known subaddress is acknowledged
              oe_n_d  = 1'b0;
              state_d = ST_CMD_ACK;
              if (rx_q == ILL_CMD_XFER && !rw_q) begin
                // Transfer lands inside the subaddress ack
                out_d = shreg_q;
              end
            end else begin
              // Unknown: no ack now, none for data either
              state_d = ST_IGNORE;
            end
          end
        end
        ST_CMD_ACK: begin
          if (scl_fall) begin
            if (cmd_q == ILL_CMD_SHIFT && rw_q) begin
              // Read: first data bit goes out on this edge
              tx_d    = shreg_q;
              oe_n_d  = shreg_q[7];
              state_d = ST_RDATA;
            end else if ((cmd_q == ILL_CMD_SHIFT ||
                          cmd_q == ILL_CMD_LOAD) && !rw_q) begin
              oe_n_d  = 1'b1;
              state_d = ST_WDATA;
            end else begin
              // 22H, or 44H with read: any data byte is ignored
              oe_n_d  = 1'b1;
              state_d = ST_IGNORE;
            end
          end
        end
        ST_WDATA: begin
          if (scl_rise) begin
            // Data byte, D7 first
            rx_d  = {rx_q[6:0], bus_q.sda};
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == ILL_BYTE_BITS) begin
            cnt_d   = 4'h0;
            oe_n_d  = 1'b0;  // Data byte acknowledged
            state_d = ST_WDAT_ACK;
            shreg_d = rx_q;  // Shift register takes the byte
            if (cmd_q == ILL_CMD_LOAD) begin
              // Output follows during the data ack
              out_d = rx_q;
            end
          end
        end
        ST_WDAT_ACK: begin
          if (scl_fall) begin
            // Only one data byte per transaction
            oe_n_d  = 1'b1;
            state_d = ST_IGNORE;
          end
        end
        ST_RDATA: begin
          if (scl_fall) begin
            cnt_d = cnt_q + 4'h1;
            if (cnt_q == ILL_BYTE_BITS - 4'h1) begin
              // Last bit done: free SDA for the controller's ack
              oe_n_d  = 1'b1;
              cnt_d   = 4'h0;
              state_d = ST_RDAT_ACK;
            end else begin
              // Open drain: release for a one, pull for a zero
              tx_d   = {tx_q[6:0], 1'b0};
              oe_n_d = tx_q[6];
            end
          end
        end
        ST_RDAT_ACK: begin
          if (scl_fall) begin
            // Ack or not, a single byte is all a read returns
            state_d = ST_IGNORE;
          end
        end
        ST_IGNORE: begin
          oe_n_d = 1'b1;  // Hands off the bus
        end
        ST_IDLE: begin
          oe_n_d = 1'b1;
        end
        default: begin
          // Illegal code: recover quietly
          state_d = ST_IDLE;
          oe_n_d  = 1'b1;
        end
      endcase
    end
  end

  // Register the engine; reset clears interface and outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      cnt_q   <= 4'h0;
      rx_q    <= 8'h00;
      rw_q    <= 1'b0;
      cmd_q   <= 8'h00;
      tx_q    <= 8'h00;
      shreg_q <= ILL_SHIFT_RST;
      out_q   <= ILL_OUT_RST;
      oe_n_q  <= 1'b1;
      sdo_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      rx_q    <= rx_d;
      rw_q    <= rw_d;
      cmd_q   <= cmd_d;
      tx_q    <= tx_d;
      shreg_q <= shreg_d;
      out_q   <= out_d;
      oe_n_q  <= oe_n_d;
      sdo_q   <= 1'b0;  // Open drain only ever drives low
    end
  end

  // Pins straight from flops; a one bit turns its transistor on
  assign output_transistor = out_q;
  assign sda_oe_n          = oe_n_q;
  assign sda_o             = sdo_q;

endmodule // ill_top
